// *** hw/lcd_cmd_dec.sv ***
// Module: I2C slave front end and command decoder of an LCD column driver
// Function
// - Drive-mode command low bits set multiplex ratio 1:8/16/24/32.
// - Drive-mode bits 3:2 set display status blank/normal/on/inverse.
// - Drive-mode bit 4 selects row-only or mixed-mode companion.
// - Bits 6:2 all ones: start-bank command, low bits pick top bank.
// - Bits 6:4 = 110: chip-select loads subaddress counter 0..15.
// - Bits 6:4 = 111: access mode, bits 3:2 pick increment order.
// - Access pattern 11 in bits 3:2 decodes as start-bank instead.
// - Access-mode low bits select RAM bank of first data byte.
// - Bit 6 clear loads column pointer; master sends 0..39 only.
// - One data bit transferred per serial clock pulse.
// - Data change while clock high is a bus control condition.
// - Bus is idle when both lines are high.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition.
// - Eight bits plus one acknowledge bit per byte, unlimited bytes.
// - Addressed receiver acknowledges address and command bytes, data bytes only while selected.
// - Acknowledger holds data low through the acknowledge clock high.
// - On read no-acknowledge device releases data line high.
// - Command bit 7 set means another command follows, else data.
// - Commands only in writes; reads return data after address ack.
// - Data moves only while subaddress counter equals subaddress pins.
// - After each written byte, or acknowledged read byte while selected, pointer advances; subaddress counter steps on wrap.
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_dec (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output var  logic             sda_o,
   output var  logic             sda_oe_o,
   input  wire logic             slave_lsb_i,
   input  wire logic [3:0]       hw_subaddr_i,
   input  wire logic [7:0]       ram_rdata_i,
   output var  lcd_pkg::lcd_cfg_s cfg_o,
   output var  lcd_pkg::lcd_ram_s ram_o,
   output var  logic [3:0]       subaddr_cnt_o,
   output var  logic             bus_busy_o
);
   import lcd_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_CMD  = 6'h04,
      ST_WDAT = 6'h08,
      ST_RDAT = 6'h10,
      ST_SKIP = 6'h20
   } lcd_st_e;

   // Two-flop synchronisers; only the second stage feeds logic
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic       scl_d_r;
   logic       sda_d_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_i};
         sda_sync_r <= {sda_sync_r[0], sda_i};
         scl_d_r    <= scl_sync_r[1];
         sda_d_r    <= sda_sync_r[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_s     = scl_sync_r[1];
   assign sda_s     = sda_sync_r[1];
   assign scl_rise  = scl_s & ~scl_d_r;
   assign scl_fall  = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // Command classes
   function automatic logic is_bank(input logic [7:0] b);
      is_bank = (b[6:2] == 5'h1f);
   endfunction

   // Column pointer advance with wrap at the last column
   function automatic logic [5:0] col_inc(input logic [5:0] c);
      col_inc = (c >= LCD_COL_LAST) ? 6'h00 : c + 6'h01;
   endfunction

   lcd_st_e    st_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic       ack_ph_r;
   logic       ack_drive_r;
   logic       read_r;
   logic       cont_r;
   logic [7:0] tx_r;
   logic       sel_ok;
   logic [7:0] byte_in;

   assign byte_in = {shift_r[6:0], sda_s};
   assign sel_ok  = (subaddr_cnt_o == hw_subaddr_i);

   // Bus busy flag: idle only once stop seen with both lines high
   always_ff @(posedge clk_i) begin
      if (srst_i)
         bus_busy_o <= 1'b0;
      else if (start_det)
         bus_busy_o <= 1'b1;
      else if (stop_det || (st_r == ST_IDLE && scl_s && sda_s))
         bus_busy_o <= 1'b0;
   end

   // Bit and byte framing
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         ack_ph_r  <= 1'b0;
      end else if (start_det || stop_det) begin
         bit_cnt_r <= 4'h0;
         ack_ph_r  <= 1'b0;
      end else if (scl_rise && !ack_ph_r) begin
         shift_r   <= byte_in;
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && bit_cnt_r == LCD_BITS_PER_BYTE) begin
         ack_ph_r  <= 1'b1;
         bit_cnt_r <= 4'h0;
      end else if (scl_fall && ack_ph_r) begin
         ack_ph_r  <= 1'b0;
      end
   end

   logic byte_done;
   logic ack_end;
   logic ack_rise;
   assign byte_done = scl_rise && !ack_ph_r && bit_cnt_r == 4'h7;
   assign ack_end   = scl_fall && ack_ph_r;
   assign ack_rise  = scl_rise && ack_ph_r;

   // Marks an acknowledge slot that follows a display byte; only those
   // slots move the pointers, never the address or command slots
   logic data_ack_r;
   always_ff @(posedge clk_i) begin
      if (srst_i)
         data_ack_r <= 1'b0;
      else if (start_det || stop_det || ack_end)
         data_ack_r <= 1'b0;
      else if (byte_done && (st_r == ST_WDAT || st_r == ST_RDAT))
         data_ack_r <= 1'b1;
   end

   // Protocol state and command decode
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r          <= ST_IDLE;
         read_r        <= 1'b0;
         cont_r        <= 1'b1;
         ack_drive_r   <= 1'b0;
         cfg_o         <= '{mux_ratio: LCD_MUX_RST,
                            display_status: LCD_STATUS_RST,
                            system_mixed: 1'b0, top_bank: 2'h0,
                            access_order: 2'h0};
         subaddr_cnt_o <= 4'h0;
         ram_o         <= '0;
      end else begin
         ram_o.we <= 1'b0;
         ram_o.re <= 1'b0;
         if (stop_det) begin
            st_r        <= ST_IDLE;
            ack_drive_r <= 1'b0;
         end else if (start_det) begin
            st_r        <= ST_ADDR;
            ack_drive_r <= 1'b0;
         end else if (byte_done) begin
            case (st_r)
               ST_ADDR: begin
                  if (byte_in[7:1] == {LCD_SLAVE_ADDR_BASE[6:1],
                                       slave_lsb_i}) begin
                     ack_drive_r <= 1'b1;
                     read_r      <= byte_in[0];
                     st_r        <= byte_in[0] ? ST_RDAT : ST_CMD;
                  end else begin
                     st_r <= ST_SKIP;
                  end
               end
               ST_CMD: begin
                  ack_drive_r <= 1'b1;
                  cont_r      <= byte_in[LCD_CONT_BIT];
                  if (!byte_in[LCD_CONT_BIT])
                     st_r <= ST_WDAT;
                  if (!byte_in[6]) begin
                     ram_o.column <= byte_in[5:0];
                  end else if (byte_in[6:5] == 2'h2) begin
                     cfg_o.mux_ratio      <= byte_in[1:0];
                     cfg_o.display_status <= byte_in[3:2];
                     cfg_o.system_mixed   <= byte_in[4];
                  end else if (is_bank(byte_in)) begin
                     cfg_o.top_bank <= byte_in[1:0];
                  end else if (byte_in[6:4] == 3'h6) begin
                     subaddr_cnt_o <= byte_in[3:0];
                  end else begin
                     cfg_o.access_order <= byte_in[3:2];
                     ram_o.bank         <= byte_in[1:0];
                  end
               end
               ST_WDAT: begin
                  if (sel_ok) begin
                     ack_drive_r <= 1'b1;
                     ram_o.we    <= 1'b1;
                     ram_o.wdata <= byte_in;
                  end
               end
               default: ;
            endcase
         end else if (ack_end) begin
            ack_drive_r <= 1'b0;
            if ((st_r == ST_WDAT || st_r == ST_RDAT) && data_ack_r) begin
               if (st_r == ST_WDAT || sel_ok) begin
                  ram_o.column <= col_inc(ram_o.column);
                  if (ram_o.column >= LCD_COL_LAST)
                     subaddr_cnt_o <= subaddr_cnt_o + 4'h1;
               end
            end
         end else if (ack_rise && read_r && st_r == ST_RDAT && sda_s) begin
            st_r <= ST_SKIP;
         end
         if (st_r == ST_RDAT && sel_ok && scl_fall && ack_ph_r)
            ram_o.re <= 1'b1;
      end
   end

   // Transmit shift register for reads; loads at end of each ack slot while in ST_RDAT
   always_ff @(posedge clk_i) begin
      if (srst_i)
         tx_r <= 8'hff;
      else if (ack_end && st_r == ST_RDAT)
         tx_r <= sel_ok ? ram_rdata_i : 8'hff;
      else if (scl_fall && !ack_ph_r && bit_cnt_r != 4'h0)
         tx_r <= {tx_r[6:0], 1'b1};
   end

   // Pin driver: open drain, only ever pulls low
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sda_o    <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_o <= 1'b0;
      end else if (scl_fall || scl_rise) begin
         sda_o <= 1'b0;
         if (ack_ph_r && !(scl_fall))
            sda_oe_o <= ack_drive_r;
         else if (scl_fall && bit_cnt_r == LCD_BITS_PER_BYTE)
            sda_oe_o <= ack_drive_r;
         // The shift register moves on this same edge, so bit 6 is next
         else if (scl_fall && st_r == ST_RDAT && !ack_ph_r)
            sda_oe_o <= ~tx_r[6];
         else if (ack_end && st_r == ST_RDAT)
            sda_oe_o <= sel_ok & ~ram_rdata_i[7];
         else if (scl_fall)
            sda_oe_o <= 1'b0;
      end
   end

   // Assertions
   ack_low_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (ack_ph_r && ack_drive_r && scl_s && !start_det)
         |-> sda_oe_o && !sda_o)
      else $error("ack not driven low");
   start_busy_a: assert property (@(posedge clk_i) disable iff (srst_i)
      start_det |=> bus_busy_o && st_r == ST_ADDR)
      else $error("start not taken");
   stop_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
      stop_det |=> st_r == ST_IDLE && !sda_oe_o)
      else $error("stop not taken");
   mode_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && byte_in[6:5] == 2'h2 && !stop_det
       && !start_det) |=> cfg_o.mux_ratio == $past(byte_in[1:0])
         && cfg_o.display_status == $past(byte_in[3:2])
         && cfg_o.system_mixed == $past(byte_in[4]))
      else $error("mode not loaded");
   bank_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && is_bank(byte_in) && !stop_det
       && !start_det) |=> cfg_o.top_bank == $past(byte_in[1:0]))
      else $error("bank not loaded");
   sub_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && byte_in[6:4] == 3'h6 && !stop_det
       && !start_det) |=> subaddr_cnt_o == $past(byte_in[3:0]))
      else $error("subaddress not loaded");
   col_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && !byte_in[6] && !stop_det
       && !start_det) |=> ram_o.column == $past(byte_in[5:0]))
      else $error("column not loaded");
   write_sel_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ram_o.we |-> $past(sel_ok))
      else $error("write while deselected");
   cont_data_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && !byte_in[7] && !stop_det
       && !start_det) |=> st_r == ST_WDAT)
      else $error("data phase missed");
   // Address and command slots must leave the column pointer alone
   ptr_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (ack_end && !data_ack_r && !start_det && !stop_det)
         |=> $stable(ram_o.column))
      else $error("pointer moved outside data");
   ptr_step_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (ack_end && data_ack_r && st_r == ST_WDAT && !start_det
       && !stop_det) |=> ram_o.column == col_inc($past(ram_o.column)))
      else $error("pointer did not advance");
   skip_quiet_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (st_r == ST_SKIP && scl_fall && !start_det) |=> !sda_oe_o)
      else $error("line driven after release");
   cmd_ack_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && !start_det && !stop_det)
         |=> ack_drive_r)
      else $error("command not acknowledged");
   sel_ack_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_WDAT && !sel_ok && !start_det
       && !stop_det) |=> !ack_drive_r && !ram_o.we)
      else $error("foreign data taken");
   access_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (byte_done && st_r == ST_CMD && byte_in[6:4] == 3'h7
       && !is_bank(byte_in) && !stop_det && !start_det)
         |=> cfg_o.access_order == $past(byte_in[3:2])
         && ram_o.bank == $past(byte_in[1:0]))
      else $error("access mode not loaded");
   read_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ram_o.re |=> !ram_o.re)
      else $error("read strobe too long");
   start_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
      start_det |=> !ack_drive_r)
      else $error("ack left armed at start");
endmodule
`default_nettype wire

// *** hw/lcd_pkg.sv ***
// Package: constants and carriers for the LCD column command decoder
package lcd_pkg;
   localparam logic [6:0] LCD_SLAVE_ADDR_BASE = 7'h3c;
   localparam logic [1:0] LCD_MUX_RST         = 2'h1;
   localparam logic [1:0] LCD_STATUS_RST      = 2'h0;
   localparam logic [5:0] LCD_COL_LAST        = 6'h27;
   localparam logic [3:0] LCD_BITS_PER_BYTE   = 4'h8;
   localparam int         LCD_OP_BIT          = 7;
   localparam int         LCD_CONT_BIT        = 7;

   typedef struct packed {
      logic [1:0] mux_ratio;
      logic [1:0] display_status;
      logic       system_mixed;
      logic [1:0] top_bank;
      logic [1:0] access_order;
   } lcd_cfg_s;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [1:0] bank;
      logic [5:0] column;
      logic [7:0] wdata;
   } lcd_ram_s;
endpackage

// *** test/lcd_i2c_master.sv ***
// Serial bus master model driving the column decoder's two-wire pins
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_pull_o
);
   // Idle bus: clock high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // A third of the 120 ns serial clock period
   task automatic q();
      repeat (10) @(negedge clk_i);
   endtask
   task automatic start();
      sda_pull_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_pull_o = 1'b1;
      q();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_pull_o = 1'b0;
      q();
   endtask
   // Data only moves while the clock is low
   task automatic bit_xfer(input logic b, output logic s);
      sda_pull_o = !b;
      q();
      scl_o = 1'b1;
      q();
      s = sda_i;
      q();
      scl_o = 1'b0;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
      bit_xfer(1'b1, s);
      ack = !s;
   endtask
   // Acknowledge every byte but the last one
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(last, s);
   endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the column command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lcd_pkg::*;
   logic       clk;
   logic       srst;
   logic       scl;
   logic       pull;
   logic       sda_o;
   logic       sda_oe;
   logic       sda;
   logic       lsb;
   lcd_cfg_s   cfg;
   lcd_ram_s   ram;
   lcd_ram_s   wr_last;
   logic [3:0] cnt;
   logic       busy;
   logic       ack;
   logic [1:0] k;
   logic [7:0] d;
   int         err_count = 0;
   int         checks_done = 0;
   int         wr_cnt = 0;
   int         rd_cnt = 0;
   // Open-drain line: low if either party pulls
   assign sda = !(pull || (sda_oe && !sda_o));
   lcd_cmd_dec i_lcd_cmd_dec (.clk_i(clk), .srst_i(srst), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .slave_lsb_i(lsb),
      .hw_subaddr_i(4'h3), .ram_rdata_i(8'ha5), .cfg_o(cfg), .ram_o(ram),
      .subaddr_cnt_o(cnt), .bus_busy_o(busy));
   lcd_i2c_master i_lcd_i2c_master (.clk_i(clk), .sda_i(sda),
      .scl_o(scl), .sda_pull_o(pull));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Strobes last one cycle, so they are caught here
   always @(posedge clk) begin
      if (ram.we === 1'b1) begin
         wr_last <= ram;
         wr_cnt <= wr_cnt + 1;
      end
      if (ram.re === 1'b1) rd_cnt <= rd_cnt + 1;
   end
   task automatic check(input string w, input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", w, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] b, input logic e);
      i_lcd_i2c_master.wbyte(b, ack);
      check("ack", ack, e);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial begin
      srst = 1'b1;
      lsb = 1'b0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      check("cfg", cfg, {LCD_MUX_RST, LCD_STATUS_RST, 5'h0});
      check("idle", {cnt, busy}, 5'h0);
      i_lcd_i2c_master.start();
      check("busy", busy, 1'b1);
      wr(8'h78, 1'b1);
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         wr({3'b110, k[0], k, k}, 1'b1);
         check("mode", {cfg.mux_ratio, cfg.display_status,
            cfg.system_mixed}, {k, k, k[0]});
         wr({6'h3f, k}, 1'b1);
         check("bank", cfg.top_bank, k);
         if (i < 3) wr({4'hf, k, k}, 1'b1);
         if (i < 3) check("order", cfg.access_order, k);
      end
      wr(8'hfd, 1'b1);
      check("shared code", {cfg.top_bank, cfg.access_order}, 4'h6);
      wr(8'he3, 1'b1);
      check("subaddr", cnt, 4'h3);
      wr(8'hf1, 1'b1);
      wr(8'h26, 1'b1);
      // Column 38, 39, then wrap hands over to the next device
      for (int i = 0; i < 3; i++) begin
         wr(8'(17 * (i + 1)), i < 2);
         if (i < 2) check("write", {wr_last.bank, wr_last.column,
            wr_last.wdata}, {2'h1, 6'(38 + i), 8'(17 * (i + 1))});
      end
      check("writes", 16'(wr_cnt), 16'h2);
      check("subaddr", cnt, 4'h4);
      i_lcd_i2c_master.stop();
      repeat (4) @(negedge clk);
      check("busy", busy, 1'b0);
      i_lcd_i2c_master.start();
      wr(8'h7a, 1'b0);
      i_lcd_i2c_master.stop();
      lsb = 1'b1;
      i_lcd_i2c_master.start();
      wr(8'h7a, 1'b1);
      i_lcd_i2c_master.stop();
      lsb = 1'b0;
      i_lcd_i2c_master.start();
      wr(8'h78, 1'b1);
      wr(8'he3, 1'b1);
      wr(8'h05, 1'b1);
      i_lcd_i2c_master.stop();
      i_lcd_i2c_master.start();
      wr(8'h79, 1'b1);
      i_lcd_i2c_master.rbyte(1'b0, d);
      check("read", d, 8'ha5);
      i_lcd_i2c_master.rbyte(1'b1, d);
      repeat (4) @(negedge clk);
      check("release", {sda_oe, sda}, 2'h1);
      check("reads", rd_cnt > 0, 1'b1);
      i_lcd_i2c_master.stop();
      finish_test();
   end
endmodule
`default_nettype wire
